// ### aatc_pkg.sv
/*
 * aatc_pkg: shared constants, states and carrier structs for the
 * acknowledged packet transaction controller.
 * Assumes a single 40 MHz clock; all times are converted to cycles here.
 */
`default_nettype none

package aatc_pkg;

    localparam int CLK_NS = 25;

    // activation hold time, least time: round up
    localparam int ACT_HOLD_NS  = 10_000;
    localparam int ACT_HOLD_CYC = (ACT_HOLD_NS + CLK_NS - 1) / CLK_NS;

    // standby_to_active_delay, least time: round up
    localparam int STBY_NS  = 130_000;
    localparam int STBY_CYC = (STBY_NS + CLK_NS - 1) / CLK_NS;

    // acknowledgement wait window, plain default
    localparam int ACK_WAIT_NS  = 250_000;
    localparam int ACK_WAIT_CYC = ACK_WAIT_NS / CLK_NS;

    localparam int PAY_W  = 32;
    localparam int TMR_W  = 16;
    localparam int ACT_W  = 9;
    localparam int RTRY_W = 4;
    localparam int PID_W  = 2;

    localparam logic [TMR_W-1:0]  TMR_RST  = 16'h0000;
    localparam logic [ACT_W-1:0]  ACT_RST  = 9'h000;
    localparam logic [RTRY_W-1:0] RTRY_RST = 4'h0;
    localparam logic [PID_W-1:0]  PID_RST  = 2'h0;
    localparam logic [1:0]        BCNT_RST = 2'h0;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_SETTLE = 3'b001,
        S_TX     = 3'b010,
        S_AWAIT  = 3'b011,
        S_ARECV  = 3'b100,
        S_LISTEN = 3'b101,
        S_TURN   = 3'b110,
        S_ACKTX  = 3'b111
    } aatc_state_e;

    typedef struct packed {
        logic receive_data_flag;
        logic transmit_done_flag;
        logic retry_limit_flag;
    } aatc_flags_s;

    typedef struct packed {
        logic             addr_match;
        logic             done;
        logic             crc_ok;
        logic             is_ack;
        logic             has_pay;
        logic [PID_W-1:0] packet_sequence_id;
        logic [PAY_W-1:0] word;
    } aatc_rx_s;

    typedef struct packed {
        aatc_state_e       st;
        logic [TMR_W-1:0]  tmr;
        logic [ACT_W-1:0]  act_cnt;
        logic              armed;
        logic [RTRY_W-1:0] retry_counter;
        logic [PID_W-1:0]  packet_sequence_id;
        logic [PID_W-1:0]  last_pid;
        logic              pid_seen;
        logic              ackpay_pend;
        logic              ack_w_pay;
        aatc_flags_s       flags;
        logic [PAY_W-1:0]  buf0;
        logic [PAY_W-1:0]  buf1;
        logic [1:0]        bcnt;
        logic              tx_pop;
        logic              ack_pop;
    } aatc_state_s;

endpackage : aatc_pkg

`default_nettype wire

// ### aatc_ctrl.sv
/*
 * aatc_ctrl: acknowledged packet transaction sequencer, transmitter and
 * receiver role, with sticky flags and a two-entry buffer toward the cpu.
 * Assumes the modem delivers one-cycle end/done pulses synchronous to mclk_i
 * and that queues outside keep payloads until popped.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - send 140 us after activation (10 us hold, then 130 us settle), end after air
// - after sending, switch to receive for ack
// - receiver flags new data, then sends ack
// - ack received: done flag, pop transmit queue
// - transmitter done flag only after ack received
// - no ack within window: resend same packet
// - address match keeps receive past window
// - ack with payload raises done and data
// - receiver ack-payload done on next new packet
// - cycle: upload, two settles, air, ack, irq
// - retry limit: flag, keep payload, await cpu
// - duplicate packet after lost ack discarded
module aatc_ctrl
    import aatc_pkg::*;
#(
    parameter int PAY_WIDTH  = PAY_W,
    parameter int SETTLE_CYC = STBY_CYC,
    parameter int WAIT_CYC   = ACK_WAIT_CYC
) (
    input  wire logic              mclk_i,                 // 40 MHz clock
    input  wire logic              sys_rst_i,              // sync reset, high
    input  wire logic              receiver_role_i,        // 1 receiver, 0 transmitter
    input  wire logic              radio_activate_i,       // radio activate bit
    input  wire logic [RTRY_W-1:0] retry_limit_setting_i,  // max retransmits
    input  wire logic              tx_q_valid_i,           // transmit queue not empty
    output logic                   tx_q_pop_o,             // drop acked packet
    input  wire logic              ack_pay_avail_i,        // ack payload queued
    output logic                   ack_pay_pop_o,          // ack payload delivered
    output logic                   air_tx_o,               // transmitter on
    output logic                   air_rx_o,               // receiver on
    output logic                   air_is_ack_o,           // frame is an ack
    output logic                   air_ack_pay_o,          // ack carries payload
    output logic [PID_W-1:0]       packet_sequence_id_o,   // id of outgoing packet
    input  wire logic              air_tx_end_i,           // time on air elapsed
    input  wire aatc_rx_s          rx_i,                   // receive side report
    output logic                   rd_valid_o,             // buffered word ready
    input  wire logic              rd_ready_i,             // cpu takes word
    output logic [PAY_W-1:0]       rd_word_o,              // buffered word
    input  wire aatc_flags_s       flag_clr_i,             // clear strobes
    output aatc_flags_s            flags_o,                // sticky flags
    output logic [RTRY_W-1:0]      retry_counter_o         // retransmits so far
);

    // timers are TMR_W wide and the buffer word is fixed by the carrier struct
    if (PAY_WIDTH != PAY_W || SETTLE_CYC < 1 || SETTLE_CYC >= 65536 ||
        WAIT_CYC < 1 || WAIT_CYC >= 65536) begin : g_bad_param
        $error("aatc_ctrl: unsupported parameter value");
    end

    localparam logic [TMR_W-1:0] SETTLE_END = TMR_W'(SETTLE_CYC - 1);
    localparam logic [TMR_W-1:0] WAIT_END   = TMR_W'(WAIT_CYC - 1);
    localparam logic [ACT_W-1:0] ACT_END    = ACT_W'(ACT_HOLD_CYC - 1);

    aatc_state_s st_r;
    aatc_state_s st_nxt;

    logic rd_pop;
    logic ack_ok;
    logic rx_dup;
    logic timeout;

    assign rd_pop  = rd_ready_i && (st_r.bcnt != BCNT_RST);
    assign ack_ok  = rx_i.done && rx_i.crc_ok && rx_i.is_ack;
    assign rx_dup  = st_r.pid_seen && (rx_i.packet_sequence_id == st_r.last_pid);
    assign timeout = (st_r.tmr == WAIT_END) && !rx_i.addr_match;

    always_comb begin
        logic       push;
        logic [PAY_W-1:0] pw;
        logic [1:0] cnt_mid;
        push    = 1'b0;
        pw      = rx_i.word;
        cnt_mid = 2'h0;
        st_nxt  = st_r;
        st_nxt.tx_pop  = 1'b0;
        st_nxt.ack_pop = 1'b0;
        st_nxt.tmr     = TMR_W'(st_r.tmr + 16'h0001);

        // clears first so that a set in the same cycle wins
        if (flag_clr_i.receive_data_flag)  st_nxt.flags.receive_data_flag  = 1'b0;
        if (flag_clr_i.transmit_done_flag) st_nxt.flags.transmit_done_flag = 1'b0;
        if (flag_clr_i.retry_limit_flag)   st_nxt.flags.retry_limit_flag   = 1'b0;

        // hold count; armed blocks relaunch until activate drops
        if (!radio_activate_i) begin
            st_nxt.act_cnt = ACT_RST;
            st_nxt.armed   = 1'b0;
        end else if (st_r.act_cnt != ACT_END) begin
            st_nxt.act_cnt = ACT_W'(st_r.act_cnt + 9'h001);
        end

        unique case (st_r.st)
            S_IDLE: begin
                if (receiver_role_i && radio_activate_i) begin
                    st_nxt.st = S_LISTEN;
                end else if (!receiver_role_i && radio_activate_i && !st_r.armed &&
                             st_r.act_cnt == ACT_END && tx_q_valid_i) begin
                    st_nxt.st    = S_SETTLE;
                    st_nxt.tmr   = TMR_RST;
                    st_nxt.armed = 1'b1;
                end
            end
            S_SETTLE: begin
                if (st_r.tmr == SETTLE_END) st_nxt.st = S_TX;
            end
            S_TX: begin
                if (air_tx_end_i) begin
                    st_nxt.st  = S_AWAIT;
                    st_nxt.tmr = TMR_RST;
                end
            end
            S_AWAIT: begin
                if (rx_i.addr_match) begin
                    st_nxt.st = S_ARECV;
                end else if (timeout) begin
                    if (st_r.retry_counter >= retry_limit_setting_i) begin
                        st_nxt.st = S_IDLE;
                        st_nxt.flags.retry_limit_flag = 1'b1;
                    end else begin
                        st_nxt.st  = S_SETTLE;
                        st_nxt.tmr = TMR_RST;
                        st_nxt.retry_counter = RTRY_W'(st_r.retry_counter + 4'h1);
                    end
                end
            end
            S_ARECV: begin
                // payload ack with full buffer counts as lost, so it comes again
                if (ack_ok && !(rx_i.has_pay && st_r.bcnt == 2'h2)) begin
                    st_nxt.st = S_IDLE;
                    st_nxt.flags.transmit_done_flag = 1'b1;
                    st_nxt.tx_pop = 1'b1;
                    st_nxt.retry_counter = RTRY_RST;
                    st_nxt.packet_sequence_id = PID_W'(st_r.packet_sequence_id + 2'h1);
                    if (rx_i.has_pay) begin
                        push = 1'b1;
                        st_nxt.flags.receive_data_flag = 1'b1;
                    end
                end else if (rx_i.done) begin
                    st_nxt.st  = S_AWAIT;
                    st_nxt.tmr = WAIT_END;
                end
            end
            S_LISTEN: begin
                if (!radio_activate_i || !receiver_role_i) begin
                    st_nxt.st = S_IDLE;
                end else if (rx_i.done && rx_i.crc_ok && !rx_i.is_ack) begin
                    if (rx_dup) begin
                        st_nxt.st  = S_TURN;
                        st_nxt.tmr = TMR_RST;
                    end else if (st_r.bcnt != 2'h2 || rd_pop) begin
                        // a full buffer refuses the packet unacked: the sender retries
                        push = 1'b1;
                        st_nxt.flags.receive_data_flag = 1'b1;
                        st_nxt.last_pid = rx_i.packet_sequence_id;
                        st_nxt.pid_seen = 1'b1;
                        st_nxt.st  = S_TURN;
                        st_nxt.tmr = TMR_RST;
                        if (st_r.ackpay_pend) begin
                            st_nxt.flags.transmit_done_flag = 1'b1;
                            st_nxt.ack_pop     = 1'b1;
                            st_nxt.ackpay_pend = 1'b0;
                        end
                    end
                end
            end
            S_TURN: begin
                if (st_r.tmr == SETTLE_END) begin
                    st_nxt.st = S_ACKTX;
                    st_nxt.ack_w_pay = ack_pay_avail_i && !st_nxt.ack_pop;
                end
            end
            S_ACKTX: begin
                if (air_tx_end_i) begin
                    st_nxt.st = S_LISTEN;
                    if (st_r.ack_w_pay) st_nxt.ackpay_pend = 1'b1;
                end
            end
        endcase

        if (!receiver_role_i && st_r.st == S_ACKTX) st_nxt.st = S_IDLE;

        // two-entry buffer: pop shifts, push lands at the tail
        cnt_mid = st_r.bcnt;
        if (rd_pop) begin
            st_nxt.buf0 = st_r.buf1;
            cnt_mid     = 2'(st_r.bcnt - 2'h1);
        end
        if (push) begin
            if (cnt_mid == 2'h0) st_nxt.buf0 = pw;
            else                 st_nxt.buf1 = pw;
            cnt_mid = 2'(cnt_mid + 2'h1);
        end
        st_nxt.bcnt = cnt_mid;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= '{st: S_IDLE, tmr: TMR_RST, act_cnt: ACT_RST, retry_counter: RTRY_RST,
                      packet_sequence_id: PID_RST, last_pid: PID_RST, bcnt: BCNT_RST, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tx_q_pop_o           = st_r.tx_pop;
    assign ack_pay_pop_o        = st_r.ack_pop;
    assign air_tx_o             = (st_r.st == S_TX) || (st_r.st == S_ACKTX);
    assign air_rx_o             = (st_r.st == S_AWAIT) || (st_r.st == S_ARECV) ||
                                  (st_r.st == S_LISTEN);
    assign air_is_ack_o         = (st_r.st == S_ACKTX);
    assign air_ack_pay_o        = st_r.ack_w_pay;
    assign packet_sequence_id_o = st_r.packet_sequence_id;
    assign rd_valid_o           = (st_r.bcnt != BCNT_RST);
    assign rd_word_o            = st_r.buf0;
    assign flags_o              = st_r.flags;
    assign retry_counter_o      = st_r.retry_counter;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_ack_pay_in;
        st_r.st == S_ARECV ##0 ack_ok && rx_i.has_pay && st_r.bcnt != 2'h2;
    endsequence

    a_act_hold: assert property (
        (st_r.st == S_IDLE && st_nxt.st == S_SETTLE) |->
            radio_activate_i && st_r.act_cnt == ACT_END)
        else $error("launch without full activate hold");
    a_settle_len: assert property (
        (st_r.st == S_SETTLE && st_nxt.st == S_TX) |-> st_r.tmr == SETTLE_END)
        else $error("transmit started at wrong settle time");
    a_tx_turn_rx: assert property (
        (st_r.st == S_TX && air_tx_end_i) |=> air_rx_o && !air_tx_o && st_r.tmr == TMR_RST)
        else $error("no switch to receive after transmit");
    a_done_after_ack: assert property (
        $rose(flags_o.transmit_done_flag) |-> $past(rx_i.done))
        else $error("done flag without received packet");
    a_retry_step: assert property (
        (st_r.st == S_AWAIT && timeout && st_r.retry_counter < retry_limit_setting_i) |=>
            st_r.st == S_SETTLE && st_r.retry_counter == $past(st_r.retry_counter) + 4'h1)
        else $error("missed retransmit after window");
    a_addr_hold: assert property (
        (st_r.st == S_ARECV && !rx_i.done) |=> st_r.st == S_ARECV [*2] or
            (st_r.st == S_ARECV ##1 st_r.st != S_ARECV))
        else $error("left receive before packet done");
    a_limit_stop: assert property (
        (st_r.st == S_AWAIT && timeout && st_r.retry_counter >= retry_limit_setting_i) |=>
            flags_o.retry_limit_flag && st_r.st == S_IDLE && !tx_q_pop_o)
        else $error("retry limit not flagged");
    a_ack_pay_flags: assert property (
        s_ack_pay_in |=> flags_o.transmit_done_flag && flags_o.receive_data_flag && tx_q_pop_o)
        else $error("ack payload flags missing");
    a_dup_drop: assert property (
        (st_r.st == S_LISTEN && rx_i.done && rx_i.crc_ok && !rx_i.is_ack && rx_dup &&
         radio_activate_i && receiver_role_i && !rd_pop) |=>
            st_r.st == S_TURN && st_r.bcnt == $past(st_r.bcnt))
        else $error("duplicate delivered or not acked");

endmodule : aatc_ctrl // aatc_ctrl

`default_nettype wire

// ### aatc_peer_model.sv
/*
 * aatc_peer_model: far-side radio for the bench. It ends every send of the
 * device after a fixed air time and plays frames on command.
 * Assumes the bench pulses send_i for one cycle and never overlaps frames.
 */
`timescale 1ns/1ps
`default_nettype none

module aatc_peer_model
    import aatc_pkg::*;
#(
    parameter int AIR_CYC = 8,
    parameter int FRM_CYC = 50
) (
    input  wire logic     mclk_i,        // bench clock
    input  wire logic     air_tx_i,      // device transmitter on
    input  wire logic     send_i,        // start one frame
    input  wire aatc_rx_s frame_i,       // frame fields
    output logic          air_tx_end_o,  // device air time over
    output aatc_rx_s      rx_o           // receive report
);
    int       air_n = 0;
    int       frm_n = 0;
    aatc_rx_s hold  = '0;
    aatc_rx_s rx_r  = '0;
    logic     end_r = 1'b0;

    // one process per output keeps a single driver on each
    assign air_tx_end_o = end_r;
    assign rx_o         = rx_r;

    // one end pulse per send of the device
    always @(posedge mclk_i) begin
        air_n <= air_tx_i ? air_n + 1 : 0;
        end_r <= air_tx_i && (air_n == AIR_CYC - 1);
    end

    // address seen long before the end, so acks outlast the window
    always @(posedge mclk_i) begin
        if (send_i) begin
            hold  <= frame_i;
            frm_n <= 1;
        end else if (frm_n != 0) begin
            frm_n <= (frm_n == FRM_CYC) ? 0 : frm_n + 1;
        end
        // fields toggle outside done so a stale value never looks valid
        rx_r            <= ~rx_r;
        rx_r.addr_match <= (frm_n == 2);
        rx_r.done       <= 1'b0;
        if (frm_n == FRM_CYC) begin
            rx_r            <= hold;
            rx_r.addr_match <= 1'b0;
            rx_r.done       <= 1'b1;
        end
    end
endmodule // aatc_peer_model

`default_nettype wire

// ### test_auto_ack_transaction_ctrl.sv
/*
 * test_auto_ack_transaction_ctrl: self-checking bench for aatc_ctrl in both
 * roles, with the peer model on the air side.
 * Assumes short settle and wait counts; inputs move and checks run 1 ns
 * after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module test_auto_ack_transaction_ctrl;
    import aatc_pkg::*;
    localparam int SET = 20;
    localparam int FRM = 50;
    logic              mclk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              receiver_role_i = 1'b0;
    logic              radio_activate_i = 1'b0;
    logic [RTRY_W-1:0] retry_limit_setting_i = 4'h1;
    logic              tx_q_valid_i = 1'b0;
    logic              ack_pay_avail_i = 1'b0;
    logic              rd_ready_i = 1'b0;
    aatc_flags_s       flag_clr_i = '0;
    logic              send = 1'b0;
    aatc_rx_s          frame = '0;
    logic              tx_q_pop_o, ack_pay_pop_o, air_tx_o, air_rx_o, air_is_ack_o;
    logic              air_ack_pay_o, air_tx_end_i, rd_valid_o;
    logic [PID_W-1:0]  packet_sequence_id_o;
    logic [PAY_W-1:0]  rd_word_o, w1, w2;
    logic [RTRY_W-1:0] retry_counter_o;
    aatc_flags_s       flags_o;
    aatc_rx_s          rx_i;
    logic [PID_W-1:0]  p;
    logic              tx_q = 1'b0;
    int                error_cnt = 0, checks = 0, cyc = 0, tx_cnt = 0, pop_cnt = 0;
    int                apop_cnt = 0, n = 0, t0 = 0;
    int                seed = 32'h3412;

    aatc_ctrl #(.SETTLE_CYC(SET), .WAIT_CYC(40)) u_aatc_ctrl (
        .mclk_i, .sys_rst_i, .receiver_role_i, .radio_activate_i, .retry_limit_setting_i,
        .tx_q_valid_i, .tx_q_pop_o, .ack_pay_avail_i, .ack_pay_pop_o, .air_tx_o, .air_rx_o,
        .air_is_ack_o, .air_ack_pay_o, .packet_sequence_id_o, .air_tx_end_i, .rx_i,
        .rd_valid_o, .rd_ready_i, .rd_word_o, .flag_clr_i, .flags_o, .retry_counter_o);

    aatc_peer_model #(.FRM_CYC(FRM)) u_aatc_peer_model (.mclk_i, .air_tx_i(air_tx_o),
        .send_i(send), .frame_i(frame), .air_tx_end_o(air_tx_end_i), .rx_o(rx_i));

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    // event counters and the hang limit
    always @(posedge mclk_i) begin
        tx_q <= air_tx_o;
        if (air_tx_o === 1'b1 && tx_q !== 1'b1) tx_cnt++;
        pop_cnt  += (tx_q_pop_o === 1'b1);
        apop_cnt += (ack_pay_pop_o === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_tx(input logic lvl);
        n = 0;
        while (air_tx_o !== lvl && n < 600) begin
            step(1);
            n++;
        end
    endtask

    task automatic clr();
        flag_clr_i = '1;
        step(1);
        flag_clr_i = '0;
    endtask

    task automatic send_frame(input logic ack, input logic pay, input logic ok,
                              input logic [PID_W-1:0] id, input logic [PAY_W-1:0] w);
        frame = '{1'b0, 1'b0, ok, ack, pay, id, w};
        send = 1'b1;
        step(1);
        send = 1'b0;
    endtask

    task automatic launch();
        radio_activate_i = 1'b0;
        step(2);
        radio_activate_i = 1'b1;
        wait_tx(1'b1);
        radio_activate_i = 1'b0;
        chk("launch delay", (n >= 419 && n <= 422), 1);
    endtask

    // receiver role: one data frame, then the ack that should or should not follow
    task automatic rx_pkt(input logic [PID_W-1:0] id, input logic [PAY_W-1:0] w,
                          input aatc_flags_s ef, input logic ack, input logic pay);
        send_frame(1'b0, 1'b0, 1'b1, id, w);
        step(FRM + 2);
        chk("rx flags", flags_o, ef);
        step(SET + 4);
        chk("ack on", air_tx_o, ack);
        chk("ack kind", air_is_ack_o, ack);
        chk("ack pay", air_ack_pay_o, pay);
        step(SET);
        chk("relisten", {air_tx_o, air_rx_o}, 2'h1);
    endtask

    initial begin
        step(2);
        sys_rst_i = 1'b0;
        chk("reset", {flags_o, air_tx_o, air_rx_o, packet_sequence_id_o}, 7'h00);
        retry_limit_setting_i = 4'h1 + 4'($random(seed) & 1);
        tx_q_valid_i = 1'b1;
        launch();
        wait_tx(1'b0);
        chk("rx on", air_rx_o, 1'b1);
        chk("done early", flags_o.transmit_done_flag, 1'b0);
        send_frame(1'b1, 1'b0, 1'b1, 2'h0, 32'h0);
        step(FRM + 2);
        chk("done", flags_o, 3'h2);
        chk("pop", pop_cnt, 1);
        chk("pid", packet_sequence_id_o, 2'h1);
        clr();
        // corrupt ack first: must resend the same packet
        launch();
        wait_tx(1'b0);
        send_frame(1'b1, 1'b0, 1'b0, 2'h1, 32'h0);
        wait_tx(1'b1);
        chk("retry", retry_counter_o, 4'h1);
        chk("same pid", packet_sequence_id_o, 2'h1);
        wait_tx(1'b0);
        w1 = $random(seed);
        send_frame(1'b1, 1'b1, 1'b1, 2'h1, w1);
        step(FRM + 2);
        chk("pay flags", flags_o, 3'h6);
        chk("pay word", rd_word_o, w1);
        chk("retry zero", retry_counter_o, 4'h0);
        chk("pop", pop_cnt, 2);
        rd_ready_i = 1'b1;
        step(1);
        rd_ready_i = 1'b0;
        chk("drained", rd_valid_o, 1'b0);
        step(5200);
        clr();
        // no answer at all: resend up to the limit, then give up
        t0 = tx_cnt;
        launch();
        n = 0;
        while (flags_o.retry_limit_flag !== 1'b1 && n < 1000) begin
            step(1);
            n++;
        end
        step(2);
        chk("sends", tx_cnt - t0, retry_limit_setting_i + 1);
        chk("kept", pop_cnt, 2);
        chk("gave up", {flags_o, air_tx_o, air_rx_o}, 5'h04);
        // receiver role
        receiver_role_i = 1'b1;
        radio_activate_i = 1'b1;
        ack_pay_avail_i = 1'b1;
        clr();
        step(2);
        chk("listen", air_rx_o, 1'b1);
        p = 2'($random(seed));
        w1 = $random(seed);
        w2 = $random(seed);
        rx_pkt(p, w1, 3'h4, 1'b1, 1'b1);
        chk("word", rd_word_o, w1);
        clr();
        // lost ack: the duplicate is acked again with the same payload
        rx_pkt(p, w2, 3'h0, 1'b1, 1'b1);
        chk("no pay pop", apop_cnt, 0);
        ack_pay_avail_i = 1'b0;
        rx_pkt(p + 2'h1, w2, 3'h6, 1'b1, 1'b0);
        chk("pay pop", apop_cnt, 1);
        clr();
        // buffer holds two words: a third is refused and not acked
        rx_pkt(p + 2'h2, w1, 3'h0, 1'b0, 1'b0);
        rd_ready_i = 1'b1;
        chk("head", rd_word_o, w1);
        step(1);
        chk("next", rd_word_o, w2);
        step(1);
        chk("empty", rd_valid_o, 1'b0);
        rd_ready_i = 1'b0;
        test_done();
    end
endmodule // test_auto_ack_transaction_ctrl

`default_nettype wire
